// file: lmac_checker.sv
// Port-level assertions for the line maintenance block
`timescale 1ns/1ps
`default_nettype none
module lmac_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Channel and line outputs
    input wire logic [15:0] ci_tx_code,
    input wire logic [3:0]  tx_awake,
    input wire logic [3:0]  tx_line_on,
    input wire logic [3:0]  downstream_sync_signal,
    input wire logic [3:0]  loop_closed,
    input wire logic [3:0]  analog_loop_mode,
    input wire logic [3:0]  single_pulse_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_read_refused: assert property (reg_rd && reg_addr == 4'h0 && ci_tx_code[3:0] == 4'hF
        |=> reg_rdata == 8'h00) else $error("counter nonzero while deactivated");
    a_reset_idle: assert property (disable iff (1'b0) reset |=> ci_tx_code == 16'hFFFF
        && tx_line_on == 4'h0) else $error("reset state wrong");
    a_loop_analog: assert property (loop_closed == analog_loop_mode)
        else $error("loop without analog mode");
    a_loop_transp: assert property ((loop_closed & ~tx_line_on) == 4'h0)
        else $error("loop stops line signal");
    a_sync_line: assert property ((downstream_sync_signal & ~tx_line_on) == 4'h0)
        else $error("sync without line on");
    a_awake_pulse: assert property (tx_awake[0] |=> !tx_awake[0] [*3])
        else $error("awake repeated too soon");
    a_pin_deact: assert property ($rose(single_pulse_mode[0]) |-> ##[0:3]
        ci_tx_code[3:0] == 4'hF) else $error("single pulse not deactivated");
    a_synced_sync: assert property ($rose(ci_tx_code[3:0] == 4'h7)
        |-> downstream_sync_signal[0]) else $error("synced without sync signal");
    c_awake: cover property (tx_awake[0]);
    c_loop: cover property (loop_closed[0]);
    c_synced: cover property (ci_tx_code[3:0] == 4'h7);
    c_pulse: cover property (single_pulse_mode[0]);
endmodule // lmac_checker
`default_nettype wire

// file: lmac_cnt_if.sv
// Control and value bundle between the channel logic and an error counter
`timescale 1ns/1ps
`default_nettype none
interface lmac_cnt_if #(parameter int W = 8);
    logic         count_en;
    logic         clear;
    logic         frame_evt;
    logic         read_clr;
    logic [W-1:0] value;

    modport ctr (input count_en, input clear, input frame_evt, input read_clr, output value);
    modport ctl (output count_en, output clear, output frame_evt, output read_clr, input value);
endinterface
`default_nettype wire

// file: lmac_err_counter.sv
// Saturating per-channel count of errored line frames
`timescale 1ns/1ps
`default_nettype none
`include "lmac_regs.svh"
module lmac_err_counter #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Channel side
    lmac_cnt_if.ctr   cnt
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (cnt.clear) begin
            next_count = '0;
        end else if (cnt.frame_evt && cnt.count_en) begin
            if (cnt.read_clr) begin
                next_count = {{(W-1){1'b0}}, 1'b1};
            end else if (count != `LMAC_ERR_MAX) begin
                next_count = count + {{(W-1){1'b0}}, 1'b1};
            end
        end else if (cnt.read_clr) begin
            next_count = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign cnt.value = count;
endmodule // lmac_err_counter
`default_nettype wire

// file: lmac_far_end.sv
// Behavioural model of the terminal end of the line
`timescale 1ns/1ps
`default_nettype none
module lmac_far_end #(
    parameter int ACK_DLY = 3
) (
    // Clock
    input wire logic       core_clk,
    // From the block
    input wire logic [3:0] tx_awake,
    input wire logic [3:0] sync_on,
    // To the block
    output logic     [3:0] ack_detect,
    output logic     [3:0] far_synced
);
    logic [4*ACK_DLY-1:0] awk_sr = '0;
    initial ack_detect = 4'h0;
    initial far_synced = 4'h0;
    always @(posedge core_clk) begin
        awk_sr     <= {awk_sr[4*ACK_DLY-5:0], tx_awake};
        // Echo path of a repeater is not modelled; plus symbols pass untouched
        ack_detect <= awk_sr[4*ACK_DLY-1 -: 4];
        // Synced only while sync arrives; never asks to deactivate
        far_synced <= sync_on;
    end
endmodule // lmac_far_end
`default_nettype wire

// file: lmac_pkg.sv
// Types shared by the line maintenance block
package lmac_pkg;

    typedef enum logic [6:0] {
        ST_DEACT    = 7'b000_0001,
        ST_AWAKING  = 7'b000_0010,
        ST_ACK_WAIT = 7'b000_0100,
        ST_AWOKEN   = 7'b000_1000,
        ST_SYNC     = 7'b001_0000,
        ST_SYNCED   = 7'b010_0000,
        ST_ACTIVE   = 7'b100_0000
    } lmac_state_e;

    typedef enum logic [1:0] {
        MS_ZERO  = 2'b00,
        MS_PLUS  = 2'b01,
        MS_MINUS = 2'b10
    } lmac_msym_e;

    typedef logic [3:0] lmac_code_t;

endpackage

// file: lmac_regs.svh
// Register offsets, codes and timing constants of the line maintenance block
`ifndef LMAC_REGS_SVH
`define LMAC_REGS_SVH

// Register indices on the plain register port
`define LMAC_REG_ERRCNT0     4'h0
`define LMAC_REG_ERRCNT1     4'h1
`define LMAC_REG_ERRCNT2     4'h2
`define LMAC_REG_ERRCNT3     4'h3
`define LMAC_REG_STATUS      4'h4
`define LMAC_REG_CTRL        4'h5
`define LMAC_CTRL_RESET      4'hF

// Status field positions: synced bits low nibble, active bits high nibble
`define LMAC_STATUS_SYNC_POS 0
`define LMAC_STATUS_ACT_POS  4

// Downstream command codes
`define LMAC_CMD_DR          4'h0
`define LMAC_CMD_RES         4'h1
`define LMAC_CMD_LTD         4'h3
`define LMAC_CMD_SSP         4'h5
`define LMAC_CMD_ARN         4'h8
`define LMAC_CMD_ARL         4'h9
`define LMAC_CMD_AR2         4'hA
`define LMAC_CMD_AR4         4'hB
`define LMAC_CMD_DID         4'hF

// Upstream indication codes
`define LMAC_IND_ARU         4'h8
`define LMAC_IND_SYNCED      4'h7
`define LMAC_IND_AIU         4'hC
`define LMAC_IND_DIU         4'hF

// Counter limit
`define LMAC_ERR_MAX         8'hFF

// Timing
`define LMAC_CLK_KHZ         250000
`define LMAC_AWAKE_RETRY_MS  12
`define LMAC_SYNC_DELAY_MS   7

`endif

// file: lmac_top.sv
// Four-channel maintenance, loop and activation control
`timescale 1ns/1ps
`default_nettype none
`include "lmac_regs.svh"
module lmac_top #(
    parameter int CH              = 4,
    parameter int AWAKE_RETRY_CYC = `LMAC_AWAKE_RETRY_MS * `LMAC_CLK_KHZ,
    parameter int SYNC_DELAY_CYC  = `LMAC_SYNC_DELAY_MS * `LMAC_CLK_KHZ
) (
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            reset,
    // Asynchronous override pins
    input  wire logic            reset_pin,
    input  wire logic            single_pulse_test_pin,
    // Register port
    input  wire logic [3:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [7:0]      reg_rdata,
    // Command/indicate channel
    input  wire logic            ci_frame,
    input  wire logic [4*CH-1:0] ci_rx_code,
    output logic      [4*CH-1:0] ci_tx_code,
    // Line receive events
    input  wire logic [CH-1:0]   line_frame,
    input  wire logic [CH-1:0]   code_violation,
    input  wire logic [CH-1:0]   rx_maint_plus,
    input  wire logic [CH-1:0]   awake_detect,
    input  wire logic [CH-1:0]   ack_detect,
    input  wire logic [CH-1:0]   far_synced,
    input  wire logic [CH-1:0]   far_transparent,
    // Line transmit control
    output logic      [CH-1:0]   tx_awake,
    output logic      [CH-1:0]   tx_ack,
    output logic      [CH-1:0]   tx_line_on,
    output logic      [CH-1:0]   downstream_sync_signal,
    output logic      [2*CH-1:0] tx_maint_sym,
    output logic      [CH-1:0]   loop_closed,
    output logic      [CH-1:0]   analog_loop_mode,
    output logic      [CH-1:0]   single_pulse_mode
);
    localparam logic [21:0] RETRY_LOAD = 22'(AWAKE_RETRY_CYC - 1);
    localparam logic [21:0] DELAY_LOAD = 22'(SYNC_DELAY_CYC - 1);

    function automatic logic is_act_req(input lmac_pkg::lmac_code_t c);
        return c[3:2] == 2'b10;
    endfunction

    function automatic logic is_halt(input lmac_pkg::lmac_code_t c);
        return (c == `LMAC_CMD_RES) || (c == `LMAC_CMD_SSP) ||
               (c == `LMAC_CMD_DR) || (c == `LMAC_CMD_LTD);
    endfunction

    // Pin synchronisers, a change counts when stages two and three agree
    logic [2:0] res_sync;
    logic [2:0] tsp_sync;
    logic       res_pin_q;
    logic       tsp_pin_q;
    logic       next_res_pin_q;
    logic       next_tsp_pin_q;

    always_comb begin
        next_res_pin_q = (res_sync[1] == res_sync[2]) ? res_sync[2] : res_pin_q;
        next_tsp_pin_q = (tsp_sync[1] == tsp_sync[2]) ? tsp_sync[2] : tsp_pin_q;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            res_sync  <= 3'h0;
            tsp_sync  <= 3'h0;
            res_pin_q <= 1'b0;
            tsp_pin_q <= 1'b0;
        end else begin
            res_sync  <= {res_sync[1:0], reset_pin};
            tsp_sync  <= {tsp_sync[1:0], single_pulse_test_pin};
            res_pin_q <= next_res_pin_q;
            tsp_pin_q <= next_tsp_pin_q;
        end
    end

    // Register file
    logic [CH-1:0] chan_en;
    logic [CH-1:0] next_chan_en;
    logic [7:0]    next_reg_rdata;
    logic [CH-1:0] read_ok;
    logic [CH-1:0] read_clr;
    logic [CH-1:0] st_synced;
    logic [CH-1:0] st_active;
    logic [7:0]    cnt_value [CH];

    lmac_cnt_if #(.W(8)) cnt_bus [CH] ();

    always_comb begin
        next_chan_en   = chan_en;
        next_reg_rdata = 8'h00;
        read_clr       = '0;
        if (reg_wr && reg_addr == `LMAC_REG_CTRL) begin
            next_chan_en = reg_wdata[CH-1:0];
        end
        if (reg_rd) begin
            if (reg_addr < 4'(CH)) begin
                if (read_ok[reg_addr[1:0]]) begin
                    next_reg_rdata               = cnt_value[reg_addr[1:0]];
                    read_clr[reg_addr[1:0]]      = 1'b1;
                end
            end else if (reg_addr == `LMAC_REG_STATUS) begin
                next_reg_rdata[`LMAC_STATUS_SYNC_POS +: CH] = st_synced;
                next_reg_rdata[`LMAC_STATUS_ACT_POS +: CH]  = st_active;
            end else if (reg_addr == `LMAC_REG_CTRL) begin
                next_reg_rdata[CH-1:0] = chan_en;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            chan_en   <= `LMAC_CTRL_RESET;
            reg_rdata <= 8'h00;
        end else begin
            chan_en   <= next_chan_en;
            reg_rdata <= next_reg_rdata;
        end
    end

    // Per-channel logic
    for (genvar ch = 0; ch < CH; ch++) begin : g_ch
        lmac_pkg::lmac_code_t  rx_code;
        lmac_pkg::lmac_code_t  prev_code;
        lmac_pkg::lmac_code_t  acc_code;
        lmac_pkg::lmac_code_t  next_prev_code;
        lmac_pkg::lmac_code_t  next_acc_code;
        lmac_pkg::lmac_code_t  cmd;
        lmac_pkg::lmac_code_t  loop_code;
        lmac_pkg::lmac_code_t  next_loop_code;
        lmac_pkg::lmac_code_t  next_ind;
        lmac_pkg::lmac_state_e state;
        lmac_pkg::lmac_state_e next_state;
        lmac_pkg::lmac_msym_e  msym;
        lmac_pkg::lmac_msym_e  next_msym;
        logic [21:0]           timer;
        logic [21:0]           next_timer;
        logic                  cnt_en;
        logic                  next_cnt_en;
        logic                  cnt_clear;
        logic                  alt;
        logic                  next_alt;
        logic                  next_awake;
        logic                  next_ack;
        logic                  line_up;

        assign rx_code = ci_rx_code[4*ch +: 4];

        // Code taken only when seen in two successive frames
        always_comb begin
            next_prev_code = prev_code;
            next_acc_code  = acc_code;
            if (ci_frame) begin
                next_prev_code = rx_code;
                if (rx_code == prev_code) begin
                    next_acc_code = rx_code;
                end
            end
        end

        // Pins override the channel's command
        always_comb begin
            if (res_pin_q) begin
                cmd = `LMAC_CMD_RES;
            end else if (tsp_pin_q) begin
                cmd = `LMAC_CMD_SSP;
            end else begin
                cmd = acc_code;
            end
        end

        assign line_up = (state == lmac_pkg::ST_SYNC) || (state == lmac_pkg::ST_SYNCED) ||
                         (state == lmac_pkg::ST_ACTIVE);

        always_comb begin
            next_state     = state;
            next_timer     = (timer != 22'h0) ? timer - 22'h1 : timer;
            next_loop_code = loop_code;
            next_cnt_en    = cnt_en;
            cnt_clear      = 1'b0;
            next_awake     = 1'b0;
            next_ack       = 1'b0;
            if (is_halt(cmd) || !chan_en[ch]) begin
                // Deactivation comes from a halt command, either override pin or a cleared chan_en bit
                next_state     = lmac_pkg::ST_DEACT;
                next_loop_code = `LMAC_CMD_ARN;
                next_cnt_en    = 1'b0;
                cnt_clear      = 1'b1;
            end else begin
                case (state)
                    lmac_pkg::ST_DEACT: begin
                        if (is_act_req(cmd)) begin
                            next_state     = lmac_pkg::ST_AWAKING;
                            next_awake     = 1'b1;
                            next_timer     = RETRY_LOAD;
                            next_loop_code = cmd;
                        end else if (awake_detect[ch]) begin
                            next_state = lmac_pkg::ST_AWOKEN;
                            next_ack   = 1'b1;
                            next_timer = DELAY_LOAD;
                        end
                    end
                    lmac_pkg::ST_AWAKING: begin
                        if (ack_detect[ch]) begin
                            next_state = lmac_pkg::ST_ACK_WAIT;
                            next_timer = DELAY_LOAD;
                        end else if (timer == 22'h0) begin
                            next_awake = 1'b1;
                            next_timer = RETRY_LOAD;
                        end
                    end
                    lmac_pkg::ST_ACK_WAIT: begin
                        if (ack_detect[ch]) begin
                            next_state = lmac_pkg::ST_AWOKEN;
                            next_ack   = 1'b1;
                            next_timer = DELAY_LOAD;
                        end else if (timer == 22'h0) begin
                            next_state = lmac_pkg::ST_SYNC;
                        end
                    end
                    lmac_pkg::ST_AWOKEN: begin
                        if (awake_detect[ch]) begin
                            next_ack   = 1'b1;
                            next_timer = DELAY_LOAD;
                        end else if (timer == 22'h0) begin
                            next_state = lmac_pkg::ST_SYNC;
                        end
                    end
                    lmac_pkg::ST_SYNC: begin
                        if (far_synced[ch]) begin
                            next_state  = lmac_pkg::ST_SYNCED;
                            next_cnt_en = 1'b1;
                        end
                    end
                    lmac_pkg::ST_SYNCED: begin
                        if (far_transparent[ch]) begin
                            next_state = lmac_pkg::ST_ACTIVE;
                        end
                    end
                    lmac_pkg::ST_ACTIVE: begin
                        next_state = lmac_pkg::ST_ACTIVE;
                    end
                    default: begin
                        next_state = lmac_pkg::ST_DEACT;
                    end
                endcase
                if (line_up && is_act_req(cmd)) begin
                    next_loop_code = cmd;
                end
            end
        end

        // Indication sent upstream
        always_comb begin
            case (state)
                lmac_pkg::ST_DEACT:  next_ind = `LMAC_IND_DIU;
                lmac_pkg::ST_SYNCED: next_ind = `LMAC_IND_SYNCED;
                lmac_pkg::ST_ACTIVE: next_ind = `LMAC_IND_AIU;
                default:             next_ind = `LMAC_IND_ARU;
            endcase
        end

        // Maintenance symbol, one per line frame
        always_comb begin
            next_msym = msym;
            next_alt  = alt;
            if (line_frame[ch]) begin
                next_msym = lmac_pkg::MS_ZERO;
                if (line_up && loop_code == `LMAC_CMD_AR2) begin
                    next_msym = lmac_pkg::MS_PLUS;
                end else if (line_up && loop_code == `LMAC_CMD_AR4) begin
                    next_msym = alt ? lmac_pkg::MS_ZERO : lmac_pkg::MS_PLUS;
                    next_alt  = !alt;
                end else begin
                    next_alt  = 1'b0;
                end
            end
        end

        always_ff @(posedge core_clk) begin
            if (reset) begin
                prev_code                   <= `LMAC_CMD_DID;
                acc_code                    <= `LMAC_CMD_DID;
                state                       <= lmac_pkg::ST_DEACT;
                timer                       <= 22'h0;
                loop_code                   <= `LMAC_CMD_ARN;
                cnt_en                      <= 1'b0;
                alt                         <= 1'b0;
                msym                        <= lmac_pkg::MS_ZERO;
                tx_awake[ch]                <= 1'b0;
                tx_ack[ch]                  <= 1'b0;
                tx_line_on[ch]              <= 1'b0;
                downstream_sync_signal[ch]  <= 1'b0;
                loop_closed[ch]             <= 1'b0;
                analog_loop_mode[ch]        <= 1'b0;
                single_pulse_mode[ch]       <= 1'b0;
                ci_tx_code[4*ch +: 4]       <= `LMAC_IND_DIU;
            end else begin
                prev_code                   <= next_prev_code;
                acc_code                    <= next_acc_code;
                state                       <= next_state;
                timer                       <= next_timer;
                loop_code                   <= next_loop_code;
                cnt_en                      <= next_cnt_en;
                alt                         <= next_alt;
                msym                        <= next_msym;
                tx_awake[ch]                <= next_awake;
                tx_ack[ch]                  <= next_ack;
                // Line signal stays on while a loop is closed
                tx_line_on[ch]              <= (next_state != lmac_pkg::ST_DEACT);
                downstream_sync_signal[ch]  <= (next_state == lmac_pkg::ST_SYNC) ||
                                               (next_state == lmac_pkg::ST_SYNCED) ||
                                               (next_state == lmac_pkg::ST_ACTIVE);
                loop_closed[ch]             <= (next_loop_code == `LMAC_CMD_ARL);
                analog_loop_mode[ch]        <= (next_loop_code == `LMAC_CMD_ARL);
                single_pulse_mode[ch]       <= (cmd == `LMAC_CMD_SSP);
                ci_tx_code[4*ch +: 4]       <= next_ind;
            end
        end

        assign tx_maint_sym[2*ch +: 2] = msym;
        assign st_synced[ch] = (state == lmac_pkg::ST_SYNCED) || (state == lmac_pkg::ST_ACTIVE);
        assign st_active[ch] = (state == lmac_pkg::ST_ACTIVE);
        assign read_ok[ch]   = st_synced[ch];

        // Far-end frames are not counted while a loop ignores them
        assign cnt_bus[ch].count_en  = cnt_en;
        assign cnt_bus[ch].clear     = cnt_clear;
        assign cnt_bus[ch].frame_evt = line_frame[ch] && !loop_closed[ch] &&
                                       (code_violation[ch] || rx_maint_plus[ch]);
        assign cnt_bus[ch].read_clr  = read_clr[ch];
        assign cnt_value[ch]         = cnt_bus[ch].value;

        lmac_err_counter #(.W(8)) u_cnt (
            .core_clk (core_clk),
            .reset    (reset),
            .cnt      (cnt_bus[ch])
        );
    end
endmodule // lmac_top
`default_nettype wire

// file: tb.sv
// Self-checking testbench of the line maintenance block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
    logic core_clk = 0, reset = 1, sp_pin = 0, rs_pin = 0, reg_wr = 0, reg_rd = 0, ci_frame = 0;
    logic [3:0] reg_addr = 0, line_frame = 0, cv = 0, mp = 0, ack, fsync, awk, lon, dsync;
    logic [3:0] lc, alm, spm, tack;
    logic [7:0] reg_wdata = 0, rdata, d;
    logic [15:0] ci_rx = 16'hFFFF, ci_tx;
    logic [7:0] msym;
    int fails = 0, checks = 0, k;
    logic [15:0] tbl [3] = '{16'h8888, 16'hAAAA, 16'hBBBB};
    logic [3:0] sym [3] = '{4'b0000, 4'b0101, 4'b0001};
    lmac_top #(.AWAKE_RETRY_CYC(20), .SYNC_DELAY_CYC(10)) uut (.core_clk, .reset,
        .reset_pin(rs_pin), .single_pulse_test_pin(sp_pin), .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata(rdata), .ci_frame, .ci_rx_code(ci_rx), .ci_tx_code(ci_tx),
        .line_frame, .code_violation(cv), .rx_maint_plus(mp), .awake_detect(4'h0),
        .ack_detect(ack), .far_synced(fsync), .far_transparent(4'h0), .tx_awake(awk),
        .tx_ack(tack), .tx_line_on(lon), .downstream_sync_signal(dsync), .tx_maint_sym(msym),
        .loop_closed(lc), .analog_loop_mode(alm), .single_pulse_mode(spm));
    lmac_far_end far (.core_clk, .tx_awake(awk), .sync_on(dsync), .ack_detect(ack),
        .far_synced(fsync));
    initial forever #2 core_clk = ~core_clk;
    task finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1; @(posedge core_clk); reg_wr <= 0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr <= a; reg_rd <= 1; @(posedge core_clk); reg_rd <= 0;
        #1 `CHK("reg", e, rdata)
        @(posedge core_clk);
    endtask
    task cmd(input logic [15:0] c);
        ci_rx <= c;
        repeat (2) begin ci_frame <= 1; @(posedge core_clk); ci_frame <= 0; @(posedge core_clk); end
    endtask
    task frames(input int n, input logic [3:0] c, input logic [3:0] m);
        repeat (n) begin
            line_frame <= 4'hF; cv <= c; mp <= m; @(posedge core_clk);
            line_frame <= 0; cv <= ~c; mp <= ~m; @(posedge core_clk);
        end
    endtask
    task wait_for(input int w, input logic [15:0] v);
        logic [15:0] s;
        for (int i = 0; i < 500; i++) begin
            #1 s = (w == 0) ? ci_tx : {15'h0, (w == 1) ? lc[0] & alm[0] : spm[0]};
            if (s === v) break;
            @(posedge core_clk);
        end
        `CHK("wait", v, s)
        if (s !== v) finish_test();
        @(posedge core_clk);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 0;
        @(posedge core_clk);
        `CHK("ci", 16'hFFFF, ci_tx)
        rd(4'h5, 8'h0F);
        wr(4'h9, 8'hFF); rd(4'h9, 8'h00);
        wr(4'h5, 8'h07); rd(4'h5, 8'h07);
        rd(4'h4, 8'h00);
        cmd(16'h8888); wait_for(0, 16'hF777);
        rd(4'h4, 8'h07); rd(4'h0, 8'h00);
        frames(3, 4'b0101, 4'b0110);
        rd(4'h0, 8'h03); rd(4'h1, 8'h03); rd(4'h2, 8'h03); rd(4'h0, 8'h00);
        frames(260, 4'hF, 4'h0); rd(4'h0, 8'hFF);
        cmd(16'h0000); wait_for(0, 16'hFFFF);
        cmd(16'h8888); wait_for(0, 16'hF777); rd(4'h1, 8'h00);
        for (k = 0; k < 3; k++) begin
            cmd(16'h0000); wait_for(0, 16'hFFFF);
            cmd(tbl[k]); wait_for(0, 16'hF777);
            frames(1, 0, 0); `CHK("sym", sym[k][1:0], msym[1:0])
            frames(1, 0, 0); `CHK("sym", sym[k][3:2], msym[1:0])
        end
        cmd(16'h9999); wait_for(1, 16'h0001);
        frames(2, 4'hF, 4'hF); rd(4'h0, 8'h00);
        cmd(16'h8888); sp_pin <= 1; wait_for(2, 16'h0001);
        #1 `CHK("ci", 12'hFFF, ci_tx[11:0])
        @(posedge core_clk);
        sp_pin <= 0; wait_for(2, 16'h0000);
        cmd(16'h5555); wait_for(2, 16'h0001);
        rs_pin <= 1; cmd(16'h8888); wait_for(2, 16'h0000);
        repeat (30) @(posedge core_clk);
        #1 `CHK("ci", 16'hFFFF, ci_tx)
        finish_test();
    end
endmodule // tb
bind lmac_top lmac_checker u_chk (.core_clk, .reset, .reg_addr, .reg_rd, .reg_rdata,
    .ci_tx_code, .tx_awake, .tx_line_on, .downstream_sync_signal, .loop_closed,
    .analog_loop_mode, .single_pulse_mode);
`default_nettype wire
